// File: logic/mcap_consts.svh
`ifndef MCAP_CONSTS_SVH
`define MCAP_CONSTS_SVH

// ==========================================================
// Register byte offsets
`define MCAP_OFF_REMAP 8'h00
`define MCAP_OFF_ASTAT 8'h04
`define MCAP_OFF_AADDR 8'h08
`define MCAP_OFF_PRIO 8'h0c
`define MCAP_OFF_ISTAT 8'h40
`define MCAP_OFF_ICLR 8'h44
`define MCAP_OFF_IEN 8'h48

// ==========================================================
// Field positions
`define MCAP_REMAP_BIT 0
`define MCAP_UNDEF_BIT 0
`define MCAP_MISAL_BIT 1
`define MCAP_SIZE_LSB 8
`define MCAP_TYPE_LSB 10
`define MCAP_LAST_LSB 16
`define MCAP_SAVED_LSB 24
`define MCAP_PRIO_STRIDE 4

// ==========================================================
// Reset values and encodings
`define MCAP_PRIO_RST 16'h3210
`define MCAP_SZ_HALF 2'h1
`define MCAP_SZ_WORD 2'h2
`define MCAP_TYP_FETCH 2'h2
`define MCAP_SRAM_PAGE 8'h02
`define MCAP_UNDEF_BASE 28'h0400000
`define MCAP_IRQ_UNDEF 0
`define MCAP_IRQ_MISAL 1

`endif

// File: logic/mcap_pkg.sv
// ==========================================================
// Types shared by the memory controller register bank
package mcap_pkg;
`include "mcap_consts.svh"

    // Bus phase: idle or write data phase pending
    typedef enum logic [0:0] {
        MCAP_PH_IDLE = 1'b0,
        MCAP_PH_WRITE = 1'b1
    } mcap_phase_type;

    // Memory zone selected for the granted access
    typedef enum logic [1:0] {
        MCAP_ZONE_NONE = 2'b00,
        MCAP_ZONE_OTHER = 2'b01,
        MCAP_ZONE_BOOT = 2'b11,
        MCAP_ZONE_SRAM = 2'b10
    } mcap_zone_type;

    // Complete state of the top module
    typedef struct packed {
        mcap_phase_type ph;
        logic [7:0] waddr;
        logic remap;
        logic undef;
        logic misal;
        logic [1:0] size;
        logic [1:0] typ;
        logic [3:0] last_src;
        logic [3:0] saved;
        logic [31:0] abt_addr;
        logic [11:0] prio;
        logic [1:0] istat;
        logic [1:0] ien;
        logic irq;
        logic [3:0] grant;
        logic abort;
        mcap_zone_type zone;
        logic [31:0] hrdata;
        logic hreadyout;
    } mcap_state_type;

endpackage : mcap_pkg

// File: logic/mcap_arbiter.sv
`timescale 1ns/1ps
// ==========================================================
// Fixed priority pick among requesting masters
module mcap_arbiter #(
    parameter int NUM_MASTERS = 4,
    parameter int PRIO_W = 3
) (
    input wire logic [NUM_MASTERS-1:0] req, // Request per master
    input wire logic [NUM_MASTERS*PRIO_W-1:0] prio, // Priority fields
    output logic [NUM_MASTERS-1:0] win, // One-hot winner
    output logic valid // Some master wins
);
    import mcap_pkg::*;

    generate
        if (NUM_MASTERS < 1 || PRIO_W < 1) begin : g_bad
            $error("mcap_arbiter: unsupported parameters");
        end
    endgenerate

    // Scan upward, replace only on a strictly greater value
    always_comb begin
        logic [PRIO_W-1:0] best;
        best = '0;
        win = '0;
        valid = 1'b0;
        for (int i = 0; i < NUM_MASTERS; i++) begin
            if (req[i] && (!valid || prio[i*PRIO_W +: PRIO_W] > best)) begin
                best = prio[i*PRIO_W +: PRIO_W];
                win = '0;
                win[i] = 1'b1;
                valid = 1'b1;
            end
        end
    end

endmodule : mcap_arbiter

// File: logic/mcap_decoder.sv
`timescale 1ns/1ps
`include "mcap_consts.svh"
// ==========================================================
// Address check and page-zero mapping of one access
module mcap_decoder (
    input wire logic [31:0] addr, // Access address
    input wire logic [1:0] size, // 00 byte, 01 half, 10 word
    input wire logic [1:0] typ, // 00 read, 01 write, 10 fetch
    input wire logic is_cpu, // Access from the processor
    input wire logic remap, // Remap state
    output logic undef, // Undefined address
    output logic misal, // Misaligned address
    output mcap_pkg::mcap_zone_type zone // Selected memory zone
);
    import mcap_pkg::*;

    logic internal;

    // Internal area is the lowest 256 Mbyte
    assign internal = (addr[31:28] == 4'h0);

    // Undefined above the last internal page
    assign undef = internal && (addr[27:0] >= `MCAP_UNDEF_BASE);

    // Alignment check, processor fetches exempt
    always_comb begin
        misal = 1'b0;
        if (!(is_cpu && typ == `MCAP_TYP_FETCH)) begin
            if (size == `MCAP_SZ_WORD) begin
                misal = (addr[1:0] != 2'b00);
            end else if (size == `MCAP_SZ_HALF) begin
                misal = addr[0];
            end
        end
    end

    // Page zero shows SRAM after remap, boot memory before
    always_comb begin
        zone = MCAP_ZONE_OTHER;
        if (internal && addr[27:20] == 8'h00) begin
            zone = remap ? MCAP_ZONE_SRAM : MCAP_ZONE_BOOT;
        end else if (internal && addr[27:20] == `MCAP_SRAM_PAGE) begin
            zone = MCAP_ZONE_SRAM;
        end
    end

endmodule : mcap_decoder

// File: logic/mcap_top.sv
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "mcap_consts.svh"
// Operation
// - Writing one to remap bit 0 flips remap; zero does nothing.
// - Each abort sets undefined flag bit 0 if cause undefined, else clears.
// - Each abort sets misaligned flag bit 1 if misaligned, else clears.
// - Size of last abort in bits 9:8: byte, half, word.
// - One-hot source of last abort in bits 19:16, others cleared.
// - Saved source bits 27:24 set per master aborting since last read.
// - Saved bit may stay zero when abort is shown in last source.
// - Reading abort status clears all saved source bits.
// - Full address of last aborted access kept in address register.
// - Four 3-bit priorities at 2:0, 6:4, 10:8, 14:12; reset 0x3210.
// - Equal priorities favour the lower master number.
// - Misaligned word or half accesses abort; processor fetches exempt.
// - With remap on, SRAM also appears at address zero.
// - Internal area accesses at or above 0x0040_0000 abort.
module mcap_top #(
    parameter int NUM_MASTERS = 4,
    parameter int PRIO_W = 3
) (
    input wire logic clk, // System clock
    input wire logic rst, // Synchronous reset
    input wire logic hsel, // Slave select
    input wire logic [31:0] haddr, // Bus address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write transfer
    input wire logic [2:0] hsize, // Transfer size
    input wire logic [31:0] hwdata, // Write data
    input wire logic hready, // Bus ready
    output logic hreadyout, // Slave ready
    output logic hresp, // Slave response
    output logic [31:0] hrdata, // Read data
    input wire logic [3:0] mst_req, // Access request per master
    input wire logic [127:0] mst_addr, // Address per master
    input wire logic [7:0] mst_size, // Size code per master
    input wire logic [7:0] mst_type, // Type code per master
    output logic [3:0] mst_grant, // One-hot access taken
    output logic mst_abort, // Taken access aborted
    output mcap_pkg::mcap_zone_type mem_zone, // Zone of taken access
    output logic remap_active, // Remap state
    output logic irq // Interrupt level
);
    import mcap_pkg::*;

    // ==========================================================
    // Elaboration checks
    generate
        if (NUM_MASTERS != 4 || PRIO_W != 3) begin : g_bad
            $error("mcap_top: only four masters with 3-bit priority");
        end
    endgenerate

    // ==========================================================
    // Helper functions

    // Spread four priority fields into the register layout
    function automatic logic [31:0] prio_to_word(input logic [11:0] p);
        logic [31:0] w;
        w = '0;
        for (int i = 0; i < 4; i++) begin
            w[i*`MCAP_PRIO_STRIDE +: 3] = p[i*3 +: 3];
        end
        return w;
    endfunction : prio_to_word

    // Gather four priority fields from the register layout
    function automatic logic [11:0] word_to_prio(input logic [31:0] w);
        logic [11:0] p;
        p = '0;
        for (int i = 0; i < 4; i++) begin
            p[i*3 +: 3] = w[i*`MCAP_PRIO_STRIDE +: 3];
        end
        return p;
    endfunction : word_to_prio

    // Build the abort status word from the state
    function automatic logic [31:0] astat_word(input mcap_state_type s);
        logic [31:0] w;
        w = '0;
        w[`MCAP_UNDEF_BIT] = s.undef;
        w[`MCAP_MISAL_BIT] = s.misal;
        w[`MCAP_SIZE_LSB +: 2] = s.size;
        w[`MCAP_TYPE_LSB +: 2] = s.typ;
        w[`MCAP_LAST_LSB +: 4] = s.last_src;
        w[`MCAP_SAVED_LSB +: 4] = s.saved;
        return w;
    endfunction : astat_word

    // ==========================================================
    // State registers
    mcap_state_type s_r;
    mcap_state_type s_nxt;

    // ==========================================================
    // Arbitration and access decode
    logic [3:0] arb_req;
    logic [3:0] arb_win;
    logic arb_valid;
    logic [31:0] sel_addr;
    logic [1:0] sel_size;
    logic [1:0] sel_type;
    logic dec_undef;
    logic dec_misal;
    mcap_zone_type dec_zone;

    // A master granted last cycle sits out one cycle to drop its request
    assign arb_req = mst_req & ~s_r.grant;

    mcap_arbiter #(
        .NUM_MASTERS(NUM_MASTERS),
        .PRIO_W(PRIO_W)
    ) u_arb (
        .req(arb_req),
        .prio(s_r.prio),
        .win(arb_win),
        .valid(arb_valid)
    );

    // Route the winner's attributes to the decoder
    always_comb begin
        sel_addr = '0;
        sel_size = '0;
        sel_type = '0;
        for (int i = 0; i < 4; i++) begin
            if (arb_win[i]) begin
                sel_addr = mst_addr[i*32 +: 32];
                sel_size = mst_size[i*2 +: 2];
                sel_type = mst_type[i*2 +: 2];
            end
        end
    end

    mcap_decoder u_dec (
        .addr(sel_addr),
        .size(sel_size),
        .typ(sel_type),
        .is_cpu(arb_win[0]),
        .remap(s_r.remap),
        .undef(dec_undef),
        .misal(dec_misal),
        .zone(dec_zone)
    );

    // ==========================================================
    // Bus address phase qualifiers
    logic bus_take;
    logic bus_rd;
    logic bus_wr;
    logic astat_read;
    logic wr_phase;

    // A transfer is taken when selected, non-idle and bus ready
    assign bus_take = hsel && htrans[1] && hready;
    assign bus_rd = bus_take && !hwrite;
    assign bus_wr = bus_take && hwrite;
    assign astat_read = bus_rd && (haddr[7:0] == `MCAP_OFF_ASTAT);
    assign wr_phase = (s_r.ph == MCAP_PH_WRITE);

    // ==========================================================
    // Next state
    always_comb begin
        logic [3:0] saved_set;
        logic [1:0] ievent;
        logic [1:0] iclear;
        saved_set = '0;
        ievent = '0;
        iclear = '0;
        s_nxt = s_r;
        s_nxt.grant = '0;
        s_nxt.abort = 1'b0;
        s_nxt.zone = MCAP_ZONE_NONE;
        s_nxt.hreadyout = 1'b1;

        // Take the winning access and capture abort details
        if (arb_valid) begin
            s_nxt.grant = arb_win;
            if (dec_undef || dec_misal) begin
                s_nxt.abort = 1'b1;
                s_nxt.undef = dec_undef;
                s_nxt.misal = dec_misal;
                s_nxt.size = sel_size;
                s_nxt.typ = sel_type;
                s_nxt.last_src = arb_win;
                s_nxt.abt_addr = sel_addr;
                // Every abort is recorded, the optional skip is not used
                saved_set = arb_win;
                ievent[`MCAP_IRQ_UNDEF] = dec_undef;
                ievent[`MCAP_IRQ_MISAL] = dec_misal;
            end else begin
                s_nxt.zone = dec_zone;
            end
        end

        // Read data is prepared at the address phase
        s_nxt.hrdata = '0;
        if (bus_rd) begin
            case (haddr[7:0])
                `MCAP_OFF_ASTAT: begin
                    s_nxt.hrdata = astat_word(s_r);
                end
                `MCAP_OFF_AADDR: begin
                    s_nxt.hrdata = s_r.abt_addr;
                end
                `MCAP_OFF_PRIO: begin
                    s_nxt.hrdata = prio_to_word(s_r.prio);
                end
                `MCAP_OFF_ISTAT: begin
                    s_nxt.hrdata = {30'h0, s_r.istat};
                end
                `MCAP_OFF_IEN: begin
                    s_nxt.hrdata = {30'h0, s_r.ien};
                end
                default: begin
                    s_nxt.hrdata = '0;
                end
            endcase
        end

        // Write data phase applies hwdata
        if (wr_phase) begin
            case (s_r.waddr)
                `MCAP_OFF_REMAP: begin
                    if (hwdata[`MCAP_REMAP_BIT]) begin
                        s_nxt.remap = !s_r.remap;
                    end
                end
                `MCAP_OFF_PRIO: begin
                    s_nxt.prio = word_to_prio(hwdata);
                end
                `MCAP_OFF_ICLR: begin
                    iclear = hwdata[1:0];
                end
                `MCAP_OFF_IEN: begin
                    s_nxt.ien = hwdata[1:0];
                end
                default: begin
                    s_nxt.ien = s_r.ien;
                end
            endcase
        end

        // Saved sources: read clears, a new abort wins over the clear
        if (astat_read) begin
            s_nxt.saved = saved_set;
        end else begin
            s_nxt.saved = s_r.saved | saved_set;
        end

        // Sticky interrupt status, event wins over clear
        s_nxt.istat = (s_r.istat & ~iclear) | ievent;
        s_nxt.irq = |(s_nxt.istat & s_nxt.ien);

        // Track the bus phase for the next cycle
        if (bus_wr) begin
            s_nxt.ph = MCAP_PH_WRITE;
            s_nxt.waddr = haddr[7:0];
        end else begin
            s_nxt.ph = MCAP_PH_IDLE;
            s_nxt.waddr = s_r.waddr;
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            s_r <= '0;
            s_r.prio <= word_to_prio({16'h0000, `MCAP_PRIO_RST});
            s_r.hreadyout <= 1'b1;
            s_r.ph <= MCAP_PH_IDLE;
            s_r.zone <= MCAP_ZONE_NONE;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ==========================================================
    // Outputs straight from the state register, hresp tied to zero
    assign hreadyout = s_r.hreadyout;
    assign hresp = 1'b0;
    assign hrdata = s_r.hrdata;
    assign mst_grant = s_r.grant;
    assign mst_abort = s_r.abort;
    assign mem_zone = s_r.zone;
    assign remap_active = s_r.remap;
    assign irq = s_r.irq;

endmodule : mcap_top

// File: verif/mcap_masters.sv
`timescale 1ns/1ps
// ==========================================================
// Four bus masters, each holding a request until granted
module mcap_masters (
    input wire logic clk, // Clock
    input wire logic [3:0] grant, // One-hot grant
    output logic [3:0] req, // Request per master
    output logic [127:0] addr, // Address per master
    output logic [7:0] size, // Size code per master
    output logic [7:0] typ // Type code per master
);
    // Idle masters at time zero
    initial begin
        req = 4'h0;
        addr = 128'h0;
        size = 8'h0;
        typ = 8'h0;
    end
    // Present one access of master i, called just after an edge
    task post(input int i, input logic [31:0] a, input logic [3:0] st);
        req[i] <= 1'b1;
        addr[32*i+:32] <= a;
        {size[2*i+:2], typ[2*i+:2]} <= st;
    endtask : post
    // Drop the request once granted; the released address turns to junk
    always @(posedge clk) begin
        for (int i = 0; i < 4; i++) begin
            if (grant[i]) begin
                req[i] <= 1'b0;
                addr[32*i+:32] <= ~addr[32*i+:32];
            end
        end
    end
endmodule : mcap_masters

// File: verif/mcap_top_assertions.sv
`timescale 1ns/1ps
// ==========================================================
// Port checker of the register bank
module mcap_chk (
    input wire logic clk, // Clock
    input wire logic rst, // Reset
    input wire logic hsel, // Slave select
    input wire logic [31:0] haddr, // Bus address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write
    input wire logic [31:0] hwdata, // Write data
    input wire logic hready, // Bus ready
    input wire logic hreadyout, // Slave ready
    input wire logic hresp, // Response
    input wire logic [31:0] hrdata, // Read data
    input wire logic [3:0] mst_req, // Requests
    input wire logic [127:0] mst_addr, // Addresses
    input wire logic [7:0] mst_size, // Sizes
    input wire logic [3:0] mst_grant, // Grants
    input wire logic mst_abort, // Abort
    input wire mcap_pkg::mcap_zone_type mem_zone, // Zone
    input wire logic remap_active // Remap state
);
    import mcap_pkg::*;
    logic rcr_wr_r;
    logic rd_r;
    // Track data phases of remap writes and of reads
    always_ff @(posedge clk) begin
        if (rst) begin
            rcr_wr_r <= 1'b0;
            rd_r <= 1'b0;
        end else begin
            rcr_wr_r <= hsel & htrans[1] & hready & hwrite & ~|haddr[7:0];
            rd_r <= hsel & htrans[1] & hready & ~hwrite;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_toggle;
        rcr_wr_r && hwdata[0];
    endsequence
    property p_flip;
        s_toggle |=> remap_active != $past(remap_active);
    endproperty
    property p_hold;
        rcr_wr_r && !hwdata[0] |=> $stable(remap_active);
    endproperty
    property p_okay;
        hresp == 1'b0 && hreadyout == 1'b1;
    endproperty
    property p_idle;
        !rd_r |-> hrdata == 32'h0;
    endproperty
    property p_one;
        $onehot0(mst_grant);
    endproperty
    property p_req;
        |mst_grant |-> (mst_grant & ~$past(mst_req)) == 4'h0;
    endproperty
    property p_nozone;
        mst_abort |-> |mst_grant && mem_zone == MCAP_ZONE_NONE;
    endproperty
    property p_misal;
        mst_grant[1] && $past(mst_size[3:2] == 2'h2 && |mst_addr[33:32])
            |-> mst_abort;
    endproperty
    property p_undef;
        mst_grant[2] && $past(mst_addr[95:92] == 4'h0
            && mst_addr[91:64] >= 28'h0400000) |-> mst_abort;
    endproperty
    property p_sram;
        mst_grant[3] && !mst_abort && $past(mst_addr[127:116] == 12'h0
            && remap_active) |-> mem_zone == MCAP_ZONE_SRAM;
    endproperty
    a_flip: assert property (p_flip)
        else $error("remap did not toggle");
    a_hold: assert property (p_hold)
        else $error("remap changed on zero write");
    a_okay: assert property (p_okay)
        else $error("bad ready or response");
    a_idle: assert property (p_idle)
        else $error("read data outside data phase");
    a_one: assert property (p_one)
        else $error("grant not one-hot");
    a_req: assert property (p_req)
        else $error("grant without request");
    a_nozone: assert property (p_nozone)
        else $error("abort without grant or with zone");
    a_misal: assert property (p_misal)
        else $error("misaligned word not aborted");
    a_undef: assert property (p_undef)
        else $error("undefined address not aborted");
    a_sram: assert property (p_sram)
        else $error("page zero not mapped to ram");
endmodule : mcap_chk

bind mcap_top mcap_chk u_chk (.clk(clk), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .mst_req(mst_req), .mst_addr(mst_addr),
    .mst_size(mst_size), .mst_grant(mst_grant), .mst_abort(mst_abort),
    .mem_zone(mem_zone), .remap_active(remap_active));

// File: verif/tb_top.sv
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench of the register bank
module tb_top;
    import mcap_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic hreadyout, hresp, mst_abort, remap_active, irq, ab, r;
    logic [31:0] hrdata, rd, p, a;
    logic [3:0] mst_req, mst_grant, mk;
    logic [127:0] mst_addr;
    logic [7:0] mst_size, mst_type;
    mcap_zone_type mem_zone, zn;
    logic [31:0] seed = 32'h8d3ca79e;
    int errors = 0;
    int num_checks = 0;
    always #2.5 clk = ~clk;
    mcap_top uut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .mst_req(mst_req), .mst_addr(mst_addr),
        .mst_size(mst_size), .mst_type(mst_type), .mst_grant(mst_grant),
        .mst_abort(mst_abort), .mem_zone(mem_zone),
        .remap_active(remap_active), .irq(irq));
    mcap_masters m (.clk(clk), .grant(mst_grant), .req(mst_req),
        .addr(mst_addr), .size(mst_size), .typ(mst_type));
    // Expectation helpers
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic logic [3:0] win(logic [31:0] q, logic [3:0] k);
        int b = -1;
        for (int i = 0; i < 4; i++)
            if (k[i] && (b < 0 || q[4*i+:3] > q[4*b+:3])) b = i;
        return 4'h1 << b;
    endfunction : win
    function automatic logic [31:0] asr(logic [1:0] c, logic [3:0] st,
        int i, logic [3:0] sv);
        return {4'h0, sv, 4'h0, 4'h1 << i, 4'h0, st[1:0], st[3:2], 6'h0, c};
    endfunction : asr
    // ==========================================================
    // Verdict, compare and wait
    task finish_test();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : finish_test
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("FAIL %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task wt(input int k);
        for (int n = 0; n < 40; n++) begin
            @(posedge clk);
            if (k < 0 ? hreadyout === 1'b1 : k > 3 ? mst_req === 4'h0
                : mst_grant[k] === 1'b1) return;
        end
        errors++;
        finish_test();
    endtask : wt
    // ==========================================================
    // Bus transfer, master access, checked abort
    task bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {24'h0, ad};
        htrans <= 2'h2;
        hwrite <= w;
        wt(-1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wt(-1);
        rd = hrdata;
    endtask : bus
    task acc(input int i, input logic [31:0] ad, input logic [3:0] st);
        @(posedge clk);
        m.post(i, ad, st);
        wt(i);
        ab = mst_abort;
        zn = mem_zone;
    endtask : acc
    task abt(input int i, input logic [31:0] ad, input logic [3:0] st,
        input logic [1:0] c);
        acc(i, ad, st);
        chk(ab, |c); // Abort
        if (c != 2'h0) begin
            bus(0, 8'h04, 0);
            chk(rd, asr(c, st, i, 4'h1 << i)); // Fields
            bus(0, 8'h08, 0);
            chk(rd, ad); // Address
        end
    endtask : abt
    // ==========================================================
    // Main sequence
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        bus(0, 8'h04, 0);
        chk(rd, 0); // Status
        bus(0, 8'h0c, 0);
        chk(rd, 32'h3210); // Reset
        bus(0, 8'h10, 0);
        chk(rd, 0);
        $display("reset test done");
        r = 1'b0;
        for (int k = 0; k < 4; k++) begin
            bus(1, 8'h00, {31'h0, k != 0});
            r ^= (k != 0);
            #1;
            chk(remap_active, r); // Toggle
        end
        acc(3, 32'h00000010, 4'b1000);
        chk(zn, MCAP_ZONE_SRAM); // Page zero
        bus(1, 8'h00, 1);
        acc(3, 32'h00000010, 4'b1000);
        chk(zn, MCAP_ZONE_BOOT); // Boot
        $display("remap test done");
        for (int t = 0; t < 24; t++) begin
            p = (t == 0) ? 32'h0 : rnd() & 32'h7777;
            mk = (t == 0) ? 4'hf : rnd();
            if (mk == 4'h0) mk = 4'h9;
            bus(1, 8'h0c, p);
            bus(0, 8'h0c, 0);
            chk(rd, p); // Fields
            @(posedge clk);
            for (int i = 0; i < 4; i++) begin
                a = rnd();
                if (mk[i]) m.post(i, {4'h1, a[27:2], 2'h0}, {3'h4, a[0]});
            end
            repeat (2) @(posedge clk);
            chk(mst_grant, win(p, mk)); // Winner
            wt(4);
        end
        $display("priority test done");
        bus(1, 8'h48, 3);
        bus(0, 8'h48, 0);
        chk(rd, 3);
        abt(1, 32'h00200002, 4'b1000, 2'b10); // Word
        chk(irq, 1);
        abt(0, 32'h00000001, 4'b1010, 2'b00); // Fetch
        abt(2, 32'h00400000, 4'b0101, 2'b01); // Half write
        abt(3, 32'h00000003, 4'b0100, 2'b10); // Half read
        abt(0, 32'h0ffffff2, 4'b1000, 2'b11); // Both
        abt(2, 32'h00500001, 4'b0010, 2'b01); // Byte
        acc(1, 32'h00200002, 4'b1000);
        acc(3, 32'h00400000, 4'b1000);
        bus(0, 8'h04, 0);
        chk(rd, asr(2'b01, 4'b1000, 3, 4'b1010)); // Saved
        bus(0, 8'h04, 0);
        chk(rd, asr(2'b01, 4'b1000, 3, 4'b0000)); // Cleared
        bus(1, 8'h08, 32'hffffffff);
        bus(0, 8'h08, 0);
        chk(rd, 32'h00400000); // Read-only
        $display("abort test done");
        bus(1, 8'h44, 3);
        bus(0, 8'h40, 0);
        chk(rd, 0);
        chk(irq, 0);
        bus(1, 8'h48, 0);
        acc(1, 32'h00200002, 4'b1000);
        bus(0, 8'h40, 0);
        chk(rd, 2);
        chk(irq, 0);
        bus(1, 8'h48, 2);
        bus(0, 8'h48, 0);
        chk(irq, 1);
        $display("interrupt test done");
        finish_test();
    end
endmodule : tb_top
